// >>> hw/sdo_defs.svh
// Offsets, field positions, reset values and widths of the data output block
`ifndef SDO_DEFS_SVH
`define SDO_DEFS_SVH

`define SDO_AW            8
`define SDO_DW            32
`define SDO_NBIT          4
`define SDO_ADDR_W        5

`define SDO_OFS_CTRL      8'h00
`define SDO_OFS_SEL       8'h04
`define SDO_OFS_FIX       8'h08
`define SDO_OFS_STAT      8'h0c

`define SDO_CTRL_SYNC     0
`define SDO_CTRL_GATE     1
`define SDO_CTRL_MUX      2
`define SDO_CTRL_W        3

`define SDO_ST_OUT_LSB    0
`define SDO_ST_IN_LSB     4
`define SDO_ST_BLOCK      8
`define SDO_ST_ACTIVE     9
`define SDO_ST_MODE_LSB   10
`define SDO_ST_ARMED      12

`define SDO_RST_CTRL      3'h0
`define SDO_RST_SEL       4'h0
`define SDO_RST_FIX       4'h0
`define SDO_OWN_LIMIT     2'h2

`endif

// >>> hw/sdo_pkg.sv
// Types shared by the data output block
package sdo_pkg;
   typedef enum logic [1:0] {
      SDO_FIRST = 2'h0,
      SDO_SYNC  = 2'h1,
      SDO_OWN   = 2'h3
   } sdo_mode_e;
endpackage

// >>> hw/sdo_sync.sv
// Two-stage synchroniser for the pin inputs
`timescale 1ns/1ps
`default_nettype none
module sdo_sync (
   input  wire logic       REF_CLK,
   input  wire logic       RST,
   input  wire logic [4:0] D,
   output logic      [4:0] Q
);
   logic [4:0] meta_r;

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         meta_r <= 5'h00;
         Q      <= 5'h00;
      end else begin
         meta_r <= D;
         Q      <= meta_r;
      end
   end
endmodule // sdo_sync
`default_nettype wire

// >>> hw/sdo_top.sv
// Data port output path with fixed driving and synchronous data I/O
//
// Behaviour
// - Output bit with select set drives the fixed value; exchanges ignored.
// - Pin index equals bit position in select and fixed value registers.
// - Select all zero by default; all pins then follow exchange data.
// - Sync inactive if flag 0; active if set, ungated or pin two low.
// - Pin two sampled at strobe fall; decides next output event.
// - Sync and gating both set keep pin two multiplexing off.
// - Trigger when call address is below previous good call address.
// - At trigger, outputs and strobe only if own data arrived last cycle.
// - Inputs captured at every trigger regardless of received data.
// - Lowest-address slave holds received data one full cycle.
// - Inputs sampled at lowest slave return in the same response.
// - First exchange after unblocking is regular: immediate sample and apply.
// - Afterwards data I/O repeats at the common trigger, fully synchronous.
// - Three consecutive own-address calls leave synchronous mode.
// - A call to another address re-enters; next own call is regular.
// - Gated lowest slave drops one value on pin rise, repeats on fall.
// - Strobe still generated in sync mode, at the trigger instead of at the own call.
// - Exchange block flag set at reset, cleared by first parameter call.
//
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "sdo_defs.svh"
module sdo_top
   import sdo_pkg::*;
(
   input  wire logic                   REF_CLK,
   input  wire logic                   RST,
   input  wire logic                   PSEL,
   input  wire logic                   PENABLE,
   input  wire logic                   PWRITE,
   input  wire logic [`SDO_AW-1:0]     PADDR,
   input  wire logic [`SDO_DW-1:0]     PWDATA,
   output logic      [`SDO_DW-1:0]     PRDATA,
   output logic                        PREADY,
   output logic                        PSLVERR,
   input  wire logic [`SDO_ADDR_W-1:0] SLAVE_ADDR,
   input  wire logic                   MASTER_IO_CALL,
   input  wire logic [`SDO_ADDR_W-1:0] CALL_ADDR,
   input  wire logic [`SDO_NBIT-1:0]   CALL_DATA,
   input  wire logic                   WRITE_PARAMETER_CALL,
   input  wire logic [`SDO_NBIT-1:0]   DATA_IN,
   input  wire logic                   PARAM_PIN_TWO,
   output logic      [`SDO_NBIT-1:0]   DATA_OUT,
   output logic                        DATA_STROBE,
   output logic      [`SDO_NBIT-1:0]   RESP_DATA,
   output logic                        PARAM_PIN_TWO_MUX_EN
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [`SDO_CTRL_W-1:0] ctrl_r;
   logic [`SDO_NBIT-1:0]   sel_r;
   logic [`SDO_NBIT-1:0]   fix_r;
   logic [`SDO_NBIT-1:0]   exch_r;
   logic [`SDO_NBIT-1:0]   pend_r;
   logic [`SDO_NBIT-1:0]   out_nxt;
   logic [`SDO_ADDR_W-1:0] prev_addr_r;
   logic [1:0]             own_cnt_r;
   logic [4:0]             pins_s;
   logic [`SDO_NBIT-1:0]   din_s;
   logic                   p2_s;
   logic                   p2_smp_r;
   logic                   block_r;
   logic                   armed_r;
   logic                   sync_en;
   logic                   gate_en;
   logic                   sync_act;
   logic                   in_sync;
   logic                   own_call;
   logic                   other_call;
   logic                   trig;
   logic                   reg_xfer;
   logic                   apb_setup;
   logic                   apb_wr;
   sdo_mode_e              mode_r;

   ////////////////////////////////////////////////////////////////////////////
   // Register decode
   function automatic logic addr_hit(input logic [`SDO_AW-1:0] a, input logic wr);
      addr_hit = (a == `SDO_OFS_CTRL) || (a == `SDO_OFS_SEL) || (a == `SDO_OFS_FIX) ||
                 ((a == `SDO_OFS_STAT) && !wr);
   endfunction

   function automatic logic [`SDO_DW-1:0] rd_val(input logic [`SDO_AW-1:0] a);
      rd_val = 32'h0000_0000;
      case (a)
         `SDO_OFS_CTRL: rd_val[`SDO_CTRL_W-1:0] = ctrl_r;
         `SDO_OFS_SEL:  rd_val[`SDO_NBIT-1:0]   = sel_r;
         `SDO_OFS_FIX:  rd_val[`SDO_NBIT-1:0]   = fix_r;
         `SDO_OFS_STAT: begin
            rd_val[`SDO_ST_OUT_LSB +: `SDO_NBIT] = DATA_OUT;
            rd_val[`SDO_ST_IN_LSB +: `SDO_NBIT]  = RESP_DATA;
            rd_val[`SDO_ST_BLOCK]                = block_r;
            rd_val[`SDO_ST_ACTIVE]               = in_sync;
            rd_val[`SDO_ST_MODE_LSB +: 2]        = mode_r;
            rd_val[`SDO_ST_ARMED]                = armed_r;
         end
         default: rd_val = 32'h0000_0000;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchroniser
   sdo_sync u_sync (
      .REF_CLK (REF_CLK),
      .RST     (RST),
      .D       ({PARAM_PIN_TWO, DATA_IN}),
      .Q       (pins_s)
   );

   assign din_s = pins_s[`SDO_NBIT-1:0];
   assign p2_s  = pins_s[`SDO_NBIT];

   ////////////////////////////////////////////////////////////////////////////
   // APB slave, answers with one access cycle
   assign apb_setup = PSEL && !PENABLE;
   assign apb_wr    = PSEL && PENABLE && PREADY && PWRITE && addr_hit(PADDR, 1'b1);

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         PREADY  <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA  <= 32'h0000_0000;
      end else begin
         PREADY <= apb_setup;
         if (apb_setup) begin
            PSLVERR <= !addr_hit(PADDR, PWRITE);
            PRDATA  <= PWRITE ? 32'h0000_0000 : rd_val(PADDR);
         end
      end
   end

   // Configuration written by any APB write, at any time
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         ctrl_r <= `SDO_RST_CTRL;
         sel_r  <= `SDO_RST_SEL;
         fix_r  <= `SDO_RST_FIX;
      end else if (apb_wr) begin
         case (PADDR)
            `SDO_OFS_CTRL: ctrl_r <= PWDATA[`SDO_CTRL_W-1:0];
            `SDO_OFS_SEL:  sel_r  <= PWDATA[`SDO_NBIT-1:0];
            `SDO_OFS_FIX:  fix_r  <= PWDATA[`SDO_NBIT-1:0];
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Call classification and trigger
   assign sync_en    = ctrl_r[`SDO_CTRL_SYNC];
   assign gate_en    = ctrl_r[`SDO_CTRL_GATE];
   assign sync_act   = sync_en && !(gate_en && p2_smp_r);
   assign in_sync    = sync_act && (mode_r == SDO_SYNC);
   assign own_call   = MASTER_IO_CALL && !block_r && (CALL_ADDR == SLAVE_ADDR);
   assign other_call = MASTER_IO_CALL && (CALL_ADDR != SLAVE_ADDR);
   assign trig       = in_sync && MASTER_IO_CALL && (CALL_ADDR < prev_addr_r);
   assign reg_xfer   = own_call && !in_sync;

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         block_r <= 1'b1;
      end else if (WRITE_PARAMETER_CALL) begin
         block_r <= 1'b0;
      end
   end

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         prev_addr_r <= 5'h00;
      end else if (MASTER_IO_CALL) begin
         prev_addr_r <= CALL_ADDR;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Synchronous mode sequencing
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         own_cnt_r <= 2'h0;
      end else if (other_call) begin
         own_cnt_r <= 2'h0;
      end else if (own_call && own_cnt_r != 2'h3) begin
         own_cnt_r <= own_cnt_r + 2'h1;
      end
   end

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         mode_r <= SDO_FIRST;
      end else if (!sync_act) begin
         mode_r <= SDO_FIRST;
      end else begin
         unique case (mode_r)
            SDO_FIRST: if (own_call) mode_r <= SDO_SYNC;
            SDO_SYNC:  if (own_call && own_cnt_r == `SDO_OWN_LIMIT) mode_r <= SDO_OWN;
            SDO_OWN:   if (other_call) mode_r <= SDO_FIRST;
            default:   mode_r <= SDO_FIRST;
         endcase
      end
   end

   // Own data held until the next trigger; leaving sync drops it
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         armed_r <= 1'b0;
         pend_r  <= 4'h0;
      end else if (in_sync && own_call) begin
         armed_r <= 1'b1;
         pend_r  <= CALL_DATA;
      end else if (trig || !in_sync) begin
         armed_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Data I/O events
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         exch_r      <= 4'h0;
         DATA_STROBE <= 1'b0;
      end else if (reg_xfer) begin
         exch_r      <= CALL_DATA;
         DATA_STROBE <= 1'b1;
      end else if (trig && armed_r) begin
         exch_r      <= pend_r;
         DATA_STROBE <= 1'b1;
      end else begin
         DATA_STROBE <= 1'b0;
      end
   end

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         RESP_DATA <= 4'h0;
      end else if (reg_xfer || trig) begin
         RESP_DATA <= din_s;
      end
   end

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         p2_smp_r <= 1'b0;
      end else if (DATA_STROBE) begin
         p2_smp_r <= p2_s;
      end
   end

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         PARAM_PIN_TWO_MUX_EN <= 1'b0;
      end else begin
         PARAM_PIN_TWO_MUX_EN <= ctrl_r[`SDO_CTRL_MUX] && !(sync_en && gate_en);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output pin selection
   genvar gi;
   generate
      for (gi = 0; gi < `SDO_NBIT; gi++) begin : g_out
         assign out_nxt[gi] = sel_r[gi] ? fix_r[gi] : exch_r[gi];
      end
   endgenerate

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         DATA_OUT <= 4'h0;
      end else begin
         DATA_OUT <= out_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (RST);

   a_fixed_drive: assert property (
      $stable(sel_r) && $stable(fix_r) |=>
      ((DATA_OUT & $past(sel_r)) == ($past(fix_r) & $past(sel_r))))
      else $error("fixed output bit not driven from fixed value");

   a_follow_exch: assert property (
      (sel_r == 4'h0) && reg_xfer ##1 (sel_r == 4'h0) |=> (DATA_OUT == $past(CALL_DATA, 2)))
      else $error("output does not follow exchange data");

   a_block_ignore: assert property (
      block_r && !trig |=> !DATA_STROBE)
      else $error("strobe while exchange blocked");

   a_sync_off: assert property (
      !sync_en |=> (mode_r == SDO_FIRST) && !armed_r)
      else $error("sync mode active with flag cleared");

   a_p2_sample: assert property (
      DATA_STROBE |=> (p2_smp_r == $past(p2_s)))
      else $error("pin two not sampled at strobe");

   a_mux_off: assert property (
      sync_en && gate_en |=> !PARAM_PIN_TWO_MUX_EN)
      else $error("pin two multiplexing not disabled");

   a_trig_fire: assert property (
      trig && armed_r |=> DATA_STROBE && (exch_r == $past(pend_r)))
      else $error("armed trigger did not fire outputs");

   a_trig_noarm: assert property (
      trig && !armed_r |=> !DATA_STROBE && $stable(exch_r))
      else $error("unarmed trigger changed outputs");

   a_lowest_hold: assert property (
      trig && own_call |=> armed_r && (pend_r == $past(CALL_DATA)))
      else $error("lowest slave data not held for next trigger");

   a_trig_sample: assert property (
      trig |=> (RESP_DATA == $past(din_s)))
      else $error("inputs not captured at trigger");

   a_first_regular: assert property (
      (mode_r == SDO_FIRST) && own_call |=> DATA_STROBE && (RESP_DATA == $past(din_s)))
      else $error("first exchange not handled as regular");

   a_exit_sync: assert property (
      in_sync && own_call && (own_cnt_r == 2'h2) |=> (mode_r == SDO_OWN))
      else $error("sync mode kept after three own calls");

   a_reenter: assert property (
      (mode_r == SDO_OWN) && other_call && sync_act |=> (mode_r == SDO_FIRST))
      else $error("sync mode not re-entered");

   c_armed_fire: cover property (trig && armed_r);
   c_own_exit:   cover property ((mode_r == SDO_SYNC) ##[1:1000] (mode_r == SDO_OWN));
   c_lowest:     cover property (trig && own_call);
   c_first_reg:  cover property ((mode_r == SDO_FIRST) && own_call);

endmodule // sdo_top
`default_nettype wire

// >>> sim/sdo_master_model.sv
// Network master model issuing exchange and parameter calls
`timescale 1ns/1ps
`default_nettype none
module sdo_master_model (
   input  wire logic       REF_CLK,
   output logic            MASTER_IO_CALL,
   output logic [4:0]      CALL_ADDR,
   output logic [3:0]      CALL_DATA,
   output logic            WRITE_PARAMETER_CALL
);
   initial begin
      MASTER_IO_CALL = 1'b0;
      CALL_ADDR = 5'h1f;
      CALL_DATA = 4'hf;
      WRITE_PARAMETER_CALL = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // One call per slot; idle fields inverted so stale values never look valid
   task automatic call(input logic [4:0] a, input logic [3:0] d);
      @(posedge REF_CLK);
      MASTER_IO_CALL <= 1'b1;
      CALL_ADDR <= a;
      CALL_DATA <= d;
      @(posedge REF_CLK);
      MASTER_IO_CALL <= 1'b0;
      CALL_ADDR <= ~a;
      CALL_DATA <= ~d;
      repeat (3) @(posedge REF_CLK);
   endtask
   task automatic write_parameter_call;
      @(posedge REF_CLK);
      WRITE_PARAMETER_CALL <= 1'b1;
      @(posedge REF_CLK);
      WRITE_PARAMETER_CALL <= 1'b0;
      repeat (3) @(posedge REF_CLK);
   endtask
endmodule // sdo_master_model
`default_nettype wire

// >>> sim/sdo_top_test.sv
// Self-checking bench of the data port output path
`timescale 1ns/1ps
`default_nettype none
`include "sdo_defs.svh"
module sdo_top_test;
   typedef struct {logic [3:0] sel, fix, cd, din, q;} sdo_row_s;
   logic        REF_CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, er;
   logic [7:0]  PADDR;
   logic [31:0] PWDATA, PRDATA, rd;
   logic [4:0]  SLAVE_ADDR, CALL_ADDR;
   logic [3:0]  CALL_DATA, DATA_IN, DATA_OUT, RESP_DATA;
   logic        MASTER_IO_CALL, WRITE_PARAMETER_CALL, PARAM_PIN_TWO;
   logic        DATA_STROBE, PARAM_PIN_TWO_MUX_EN;
   int          error_cnt = 0, n_compared = 0, strobes = 0, cyc = 0;
   sdo_row_s    rows [5] = '{'{4'h0, 4'h0, 4'ha, 4'h3, 4'ha}, '{4'hf, 4'h5, 4'ha, 4'hc, 4'h5},
      '{4'h3, 4'h1, 4'hc, 4'h6, 4'hd}, '{4'h8, 4'h0, 4'hf, 4'h9, 4'h7},
      '{4'h1, 4'h1, 4'h6, 4'h0, 4'h7}};
   sdo_top u_dut (.REF_CLK(REF_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
      .PSLVERR(PSLVERR), .SLAVE_ADDR(SLAVE_ADDR), .MASTER_IO_CALL(MASTER_IO_CALL),
      .CALL_ADDR(CALL_ADDR), .CALL_DATA(CALL_DATA), .DATA_IN(DATA_IN),
      .WRITE_PARAMETER_CALL(WRITE_PARAMETER_CALL), .PARAM_PIN_TWO(PARAM_PIN_TWO),
      .DATA_OUT(DATA_OUT), .DATA_STROBE(DATA_STROBE), .RESP_DATA(RESP_DATA),
      .PARAM_PIN_TWO_MUX_EN(PARAM_PIN_TWO_MUX_EN));
   sdo_master_model u_mst (.REF_CLK(REF_CLK), .MASTER_IO_CALL(MASTER_IO_CALL),
      .CALL_ADDR(CALL_ADDR), .CALL_DATA(CALL_DATA),
      .WRITE_PARAMETER_CALL(WRITE_PARAMETER_CALL));
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      REF_CLK = 1'b0;
      forever #20 REF_CLK = ~REF_CLK;
   end
   always @(posedge REF_CLK) begin
      if (DATA_STROBE === 1'b1) strobes <= strobes + 1;
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         error_cnt++;
         test_done;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
      n_compared++;
      if (g !== e) begin
         error_cnt++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge REF_CLK);
      PSEL <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge REF_CLK);
      PENABLE <= 1'b1;
      do begin
         @(posedge REF_CLK);
      end while (PREADY !== 1'b1);
      rd = PRDATA;
      er = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      chk({31'h0, PREADY}, 32'h1, "no ready");
   endtask
   task automatic xchg(input logic [4:0] a, input logic [3:0] d, input logic [3:0] q, input int s);
      int s0;
      s0 = strobes;
      u_mst.call(a, d);
      chk({28'h0, DATA_OUT}, {28'h0, q}, "data out");
      chk(strobes - s0, s, "strobe count");
   endtask
   task automatic test_done;
      $display("errors %0d compared %0d", error_cnt, n_compared);
      if (error_cnt == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {PSEL, PENABLE, PWRITE, PADDR, PWDATA, DATA_IN, PARAM_PIN_TWO} = '0;
      SLAVE_ADDR = 5'h05;
      RST = 1'b1;
      repeat (10) @(posedge REF_CLK);
      RST <= 1'b0;
      apb(1'b0, `SDO_OFS_SEL, 32'h0);
      chk(rd, 32'h0, "select reset");
      apb(1'b0, 8'h10, 32'h0);
      chk({31'h0, er}, 32'h1, "unmapped");
      apb(1'b1, `SDO_OFS_STAT, 32'h0);
      chk({31'h0, er}, 32'h1, "status write");
      xchg(5'h05, 4'ha, 4'h0, 0);
      u_mst.write_parameter_call();
      foreach (rows[i]) begin
         apb(1'b1, `SDO_OFS_SEL, {28'h0, rows[i].sel});
         apb(1'b1, `SDO_OFS_FIX, {28'h0, rows[i].fix});
         DATA_IN <= rows[i].din;
         repeat (3) @(posedge REF_CLK);
         xchg(5'h05, rows[i].cd, rows[i].q, 1);
         chk({28'h0, RESP_DATA}, {28'h0, rows[i].din}, "response");
      end
      apb(1'b1, `SDO_OFS_SEL, 32'h0);
      apb(1'b1, `SDO_OFS_CTRL, 32'h1);
      xchg(5'h05, 4'h1, 4'h1, 1);
      DATA_IN <= 4'h9;
      u_mst.call(5'h06, 4'h0);
      xchg(5'h01, 4'h0, 4'h1, 0);
      chk({28'h0, RESP_DATA}, 32'h9, "trigger sample");
      xchg(5'h05, 4'h2, 4'h1, 0);
      u_mst.call(5'h06, 4'h0);
      xchg(5'h01, 4'h0, 4'h2, 1);
      xchg(5'h05, 4'h3, 4'h2, 0);
      xchg(5'h05, 4'h4, 4'h2, 0);
      xchg(5'h05, 4'h5, 4'h2, 0);
      xchg(5'h05, 4'h6, 4'h6, 1);
      u_mst.call(5'h06, 4'h0);
      xchg(5'h05, 4'h7, 4'h7, 1);
      apb(1'b1, `SDO_OFS_CTRL, 32'h7);
      repeat (2) @(posedge REF_CLK);
      chk({31'h0, PARAM_PIN_TWO_MUX_EN}, 32'h0, "mux gated");
      apb(1'b1, `SDO_OFS_CTRL, 32'h5);
      repeat (2) @(posedge REF_CLK);
      chk({31'h0, PARAM_PIN_TWO_MUX_EN}, 32'h1, "mux free");
      apb(1'b1, `SDO_OFS_CTRL, 32'h3);
      PARAM_PIN_TWO <= 1'b1;
      xchg(5'h05, 4'h8, 4'h7, 0);
      u_mst.call(5'h06, 4'h0);
      xchg(5'h01, 4'h0, 4'h8, 1);
      xchg(5'h05, 4'h9, 4'h9, 1);
      PARAM_PIN_TWO <= 1'b0;
      DATA_IN <= 4'h4;
      xchg(5'h05, 4'ha, 4'ha, 1);
      xchg(5'h05, 4'hb, 4'hb, 1);
      u_mst.call(5'h06, 4'h0);
      xchg(5'h05, 4'hc, 4'hb, 0);
      u_mst.call(5'h06, 4'h0);
      xchg(5'h05, 4'hd, 4'hc, 1);
      chk({28'h0, RESP_DATA}, 32'h4, "lowest response");
      RST <= 1'b1;
      repeat (2) @(posedge REF_CLK);
      RST <= 1'b0;
      chk({28'h0, DATA_OUT}, 32'h0, "reset output");
      xchg(5'h05, 4'h3, 4'h0, 0);
      test_done;
   end
endmodule // sdo_top_test
`default_nettype wire
